// >>> design/axis_parallel_io_handshake.sv
// Overview of operation
// - point number sampled on start or teach
// - jog held in manual, stop on release
// - speed switch reuses jog plus outside manual
// - manual input sets manual mode and status
// - origin runs homing; positioning waits for it
// - interlock needed; drop causes decelerating stop
// - start positions to point, only outside manual
// - teach stores current position at point
// - reset edge clears clearable alarm
// - reset edge clears point outputs, remaining travel
// - servo follows input, refused during alarm
// - point outputs show point, alarm number overrides
// - four outputs each pick status by code
// - busy while operating or run command active
// - end off at start, on at normal end
// - end held off while run command stays on
// - alarm_n high normally, low on alarm
// - point window flag latched until next positioning
// - near flag latched until next positioning
// - homed flag and push flag shown
// - zone flag only after homing, within bounds
// - moving flag when speed exceeds threshold
// - default selects: window, near, push, homed
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "axis_io_cfg.svh"

module axis_parallel_io_handshake
  import axis_io_pkg::*;
(
  input  wire logic                  clk_sys,               // 100 MHz clock
  input  wire logic                  rst_n,                 // async reset
  // avalon-mm slave
  input  wire logic [`AIO_ADDR_W-1:0] avs_address,          // byte address
  input  wire logic                  avs_read,              // read request
  input  wire logic                  avs_write,             // write request
  input  wire logic [31:0]           avs_writedata,         // write data
  input  wire logic [3:0]            avs_byteenable,        // byte lanes
  output var  logic [31:0]           avs_readdata,          // read data
  output var  logic                  avs_waitrequest,       // stall
  // host pins
  input  wire logic [7:0]            point_select_lines,    // point number
  input  wire logic                  jog_positive_input,    // jog plus/speed
  input  wire logic                  jog_negative_input,    // jog minus
  input  wire logic                  manual_input,          // manual mode
  input  wire logic                  origin_search_input,   // homing request
  input  wire logic                  interlock_input,       // motion enable
  input  wire logic                  start_input,           // start
  input  wire logic                  teach_input,           // position teach
  input  wire logic                  reset_input,           // alarm reset
  input  wire logic                  servo_input,           // servo request
  output var  logic [7:0]            point_number_outputs,  // point/alarm no
  output var  logic [3:0]            selectable_outputs,    // control outs
  output var  logic                  busy_output,           // in progress
  output var  logic                  end_output,            // normal end
  output var  logic                  alarm_n,               // low on alarm
  output var  logic                  drive_on_status,       // servo is on
  // motion core, same clock
  input  wire logic                  run_cmd_active,        // run command
  input  wire logic                  op_done,               // normal end pulse
  input  wire logic                  op_error,              // error end pulse
  input  wire logic [31:0]           cur_pos,               // axis position
  input  wire logic [31:0]           cur_speed,             // actual speed
  input  wire logic [31:0]           target_pos,            // point target
  input  wire logic [31:0]           zone_plus,             // point zone top
  input  wire logic [31:0]           zone_minus,            // point zone low
  input  wire logic [31:0]           near_width,            // near tolerance
  input  wire logic                  push_active,           // push running
  input  wire logic                  alarm_active,          // alarm present
  input  wire logic                  alarm_clearable,       // clear allowed
  input  wire logic [7:0]            alarm_number,          // alarm code
  input  wire logic                  warn_active,           // warning alarm
  input  wire logic                  estop_active,          // emergency stop
  input  wire logic                  rcom_active,           // cmd response
  output var  logic                  move_start,            // start pulse
  output var  logic [7:0]            move_point,            // point to run
  output var  logic                  teach_store,           // teach pulse
  output var  logic [7:0]            teach_point,           // point to store
  output var  logic                  home_start,            // homing pulse
  output var  logic                  jog_pos_cmd,           // jog plus level
  output var  logic                  jog_neg_cmd,           // jog minus level
  output var  logic                  decel_stop,            // stop pulse
  output var  logic                  speed_level_select,    // high speed
  output var  logic                  alarm_clear,           // clear pulse
  output var  logic                  remaining_clear        // drop remainder
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic in_range(input pos_t p, input pos_t lo,
                                    input pos_t hi);
    in_range = (p >= lo) && (p <= hi);
  endfunction : in_range

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_be = r;
  endfunction : merge_be

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [`AIO_PIN_W-1:0] pins_s;
  logic [7:0]            point_s;
  logic                  jog_pos_s;
  logic                  jog_neg_s;
  logic                  manual_s;
  logic                  origin_s;
  logic                  lock_s;
  logic                  start_s;
  logic                  teach_s;
  logic                  reset_s;
  logic                  servo_s;

  pin_sync #(.W(`AIO_PIN_W)) u_pin_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  ({servo_input, reset_input, teach_input, start_input,
               interlock_input, origin_search_input, manual_input,
               jog_negative_input, jog_positive_input,
               point_select_lines}),
    .pin_out (pins_s)
  );

  assign {servo_s, reset_s, teach_s, start_s, lock_s, origin_s,
          manual_s, jog_neg_s, jog_pos_s, point_s} = pins_s;

  logic start_d1_q;
  logic teach_d1_q;
  logic origin_d1_q;
  logic reset_d1_q;
  logic lock_d1_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_d1_q  <= 1'b0;
      teach_d1_q  <= 1'b0;
      origin_d1_q <= 1'b0;
      reset_d1_q  <= 1'b0;
      lock_d1_q   <= 1'b0;
    end else begin
      start_d1_q  <= start_s;
      teach_d1_q  <= teach_s;
      origin_d1_q <= origin_s;
      reset_d1_q  <= reset_s;
      lock_d1_q   <= lock_s;
    end
  end

  logic start_rise;
  logic teach_rise;
  logic origin_rise;
  logic reset_rise;
  logic lock_fall;

  assign start_rise  = start_s  & ~start_d1_q;
  assign teach_rise  = teach_s  & ~teach_d1_q;
  assign origin_rise = origin_s & ~origin_d1_q;
  assign reset_rise  = reset_s  & ~reset_d1_q;
  assign lock_fall   = ~lock_s  & lock_d1_q;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic        spdsw_q;
  logic [15:0] outsel_q;
  logic [31:0] thresh_q;
  logic [31:0] zone_lo_q;
  logic [31:0] zone_hi_q;
  logic        wr_go;
  logic [31:0] status_word;

  op_state_t   state_q;
  logic        homed_q;
  logic        pwin_q;
  logic        near_q;
  logic        zone_q;
  logic        moving_q;
  logic        manual_q;
  logic [7:0]  cur_point_q;

  assign wr_go = avs_write & ~avs_waitrequest;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spdsw_q   <= `AIO_CTRL_RST;
      outsel_q  <= `AIO_OUTSEL_RST;
      thresh_q  <= `AIO_THRESH_RST;
      zone_lo_q <= `AIO_ZONE_LO_RST;
      zone_hi_q <= `AIO_ZONE_HI_RST;
    end else if (wr_go) begin
      unique case (avs_address)
        `AIO_OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            spdsw_q <= avs_writedata[`AIO_CTRL_SPDSW_BIT];
          end
        end
        `AIO_OFS_OUTSEL: begin
          outsel_q <= 16'(merge_be({16'h0000, outsel_q}, avs_writedata,
                                   avs_byteenable));
        end
        `AIO_OFS_THRESH: begin
          thresh_q <= merge_be(thresh_q, avs_writedata, avs_byteenable);
        end
        `AIO_OFS_ZONE_LO: begin
          zone_lo_q <= merge_be(zone_lo_q, avs_writedata, avs_byteenable);
        end
        `AIO_OFS_ZONE_HI: begin
          zone_hi_q <= merge_be(zone_hi_q, avs_writedata, avs_byteenable);
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`AIO_ST_BUSY]     = busy_output;
    status_word[`AIO_ST_END]      = end_output;
    status_word[`AIO_ST_ALARM_N]  = alarm_n;
    status_word[`AIO_ST_DRIVE_ON] = drive_on_status;
    status_word[`AIO_ST_MANUAL]   = manual_q;
    status_word[`AIO_ST_HOMED]    = homed_q;
    status_word[`AIO_ST_PWIN]     = pwin_q;
    status_word[`AIO_ST_NEAR]     = near_q;
    status_word[`AIO_ST_PUSH]     = push_active;
    status_word[`AIO_ST_ZONE]     = zone_q;
    status_word[`AIO_ST_MOVING]   = moving_q;
    status_word[`AIO_ST_SPEED_HI] = speed_level_select;
    status_word[`AIO_ST_STATE_LSB +: 2] = state_q;
    status_word[`AIO_ST_POINT_LSB +: 8] = cur_point_q;
  end

  // one wait cycle, then a single low cycle completes the access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      unique case (avs_address)
        `AIO_OFS_CTRL:    avs_readdata <= {31'h0, spdsw_q};
        `AIO_OFS_OUTSEL:  avs_readdata <= {16'h0000, outsel_q};
        `AIO_OFS_THRESH:  avs_readdata <= thresh_q;
        `AIO_OFS_ZONE_LO: avs_readdata <= zone_lo_q;
        `AIO_OFS_ZONE_HI: avs_readdata <= zone_hi_q;
        `AIO_OFS_STATUS:  avs_readdata <= status_word;
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // modes, servo, alarm
  // ****************************************************************
  logic motion_ok;

  assign motion_ok = lock_s & drive_on_status & ~alarm_active;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      manual_q           <= 1'b0;
      drive_on_status    <= 1'b0;
      alarm_n            <= 1'b0;
      jog_pos_cmd        <= 1'b0;
      jog_neg_cmd        <= 1'b0;
      speed_level_select <= 1'b0;
      alarm_clear        <= 1'b0;
      remaining_clear    <= 1'b0;
    end else begin
      manual_q        <= manual_s;
      drive_on_status <= servo_s & ~alarm_active;
      alarm_n         <= ~alarm_active;
      // release of the jog level makes the core decelerate
      jog_pos_cmd <= manual_s & jog_pos_s & motion_ok;
      jog_neg_cmd <= manual_s & jog_neg_s & motion_ok;
      speed_level_select <= spdsw_q & ~manual_s & jog_pos_s;
      alarm_clear     <= reset_rise & alarm_active & alarm_clearable;
      remaining_clear <= reset_rise;
    end
  end

  // ****************************************************************
  // operation sequencing
  // ****************************************************************
  logic end_wait_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= OP_IDLE;
      homed_q     <= 1'b0;
      move_start  <= 1'b0;
      move_point  <= 8'h00;
      home_start  <= 1'b0;
      teach_store <= 1'b0;
      teach_point <= 8'h00;
      decel_stop  <= 1'b0;
      end_output  <= 1'b0;
      end_wait_q  <= 1'b0;
      cur_point_q <= 8'h00;
    end else begin
      move_start  <= 1'b0;
      home_start  <= 1'b0;
      teach_store <= 1'b0;
      decel_stop  <= 1'b0;
      if (end_wait_q && !run_cmd_active) begin
        end_wait_q <= 1'b0;
        end_output <= 1'b1;
      end
      if (reset_rise) begin
        cur_point_q <= 8'h00;
      end
      unique case (state_q)
        OP_IDLE: begin
          if (origin_rise && motion_ok && !manual_s) begin
            state_q    <= OP_HOME;
            home_start <= 1'b1;
            homed_q    <= 1'b0;
            end_output <= 1'b0;
            end_wait_q <= 1'b0;
          end else if (start_rise && !manual_s && homed_q && motion_ok) begin
            state_q     <= OP_MOVE;
            move_start  <= 1'b1;
            move_point  <= point_s;
            cur_point_q <= point_s;
            end_output  <= 1'b0;
            end_wait_q  <= 1'b0;
          end else if (teach_rise && manual_s) begin
            teach_store <= 1'b1;
            teach_point <= point_s;
          end
        end
        OP_HOME, OP_MOVE: begin
          if (lock_fall) begin
            decel_stop <= 1'b1;
          end
          if (op_error) begin
            state_q <= OP_IDLE;
          end else if (op_done) begin
            state_q <= OP_IDLE;
            if (state_q == OP_HOME) begin
              homed_q <= 1'b1;
            end
            if (run_cmd_active) begin
              end_wait_q <= 1'b1;
            end else begin
              end_output <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_output <= 1'b0;
    end else begin
      busy_output <= (state_q != OP_IDLE) | run_cmd_active;
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  pos_t     diff;
  pos_t     abs_diff;

  always_comb begin
    diff     = pos_t'(cur_pos) - pos_t'(target_pos);
    abs_diff = diff[31] ? -diff : diff;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwin_q   <= 1'b0;
      near_q   <= 1'b0;
      zone_q   <= 1'b0;
      moving_q <= 1'b0;
    end else begin
      if (move_start) begin
        pwin_q <= 1'b0;
        near_q <= 1'b0;
      end else if (state_q == OP_MOVE) begin
        if (in_range(cur_pos, zone_minus, zone_plus)) begin
          pwin_q <= 1'b1;
        end
        if (abs_diff <= pos_t'(near_width)) begin
          near_q <= 1'b1;
        end
      end
      zone_q   <= homed_q & in_range(cur_pos, zone_lo_q, zone_hi_q);
      moving_q <= cur_speed > thresh_q;
    end
  end

  // ****************************************************************
  // pin outputs
  // ****************************************************************
  logic [`AIO_NUM_CODES-1:0] status_vec;
  logic [3:0]                sel_out;

  assign status_vec = {rcom_active, estop_active, manual_q, ~warn_active,
                       moving_q, zone_q, homed_q, push_active,
                       near_q, pwin_q, 1'b0};

  for (genvar g = 0; g < `AIO_NUM_OUTS; g++) begin : g_sel
    status_select u_sel (
      .status_vec (status_vec),
      .sel        (outsel_q[g*`AIO_SEL_W +: `AIO_SEL_W]),
      .sel_out    (sel_out[g])
    );
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      selectable_outputs   <= 4'h0;
      point_number_outputs <= 8'h00;
    end else begin
      selectable_outputs   <= sel_out;
      point_number_outputs <= alarm_active ? alarm_number
                                           : cur_point_q;
    end
  end

endmodule : axis_parallel_io_handshake

`default_nettype wire

// >>> design/axis_io_cfg.svh
`ifndef AXIS_IO_CFG_SVH
`define AXIS_IO_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define AIO_ADDR_W       6
`define AIO_OFS_CTRL     6'h00
`define AIO_OFS_OUTSEL   6'h04
`define AIO_OFS_THRESH   6'h08
`define AIO_OFS_ZONE_LO  6'h0c
`define AIO_OFS_ZONE_HI  6'h10
`define AIO_OFS_STATUS   6'h14

// ****************************************************************
// reset values
// ****************************************************************
`define AIO_CTRL_RST     1'b0
`define AIO_OUTSEL_RST   16'h4321
`define AIO_THRESH_RST   32'h0000_0000
`define AIO_ZONE_LO_RST  32'h0000_0000
`define AIO_ZONE_HI_RST  32'h0000_0000

// ****************************************************************
// field positions
// ****************************************************************
`define AIO_CTRL_SPDSW_BIT   0
`define AIO_SEL_W            4
`define AIO_NUM_OUTS         4
`define AIO_NUM_CODES        11
`define AIO_ST_BUSY          0
`define AIO_ST_END           1
`define AIO_ST_ALARM_N       2
`define AIO_ST_DRIVE_ON      3
`define AIO_ST_MANUAL        4
`define AIO_ST_HOMED         5
`define AIO_ST_PWIN          6
`define AIO_ST_NEAR          7
`define AIO_ST_PUSH          8
`define AIO_ST_ZONE          9
`define AIO_ST_MOVING        10
`define AIO_ST_SPEED_HI      11
`define AIO_ST_STATE_LSB     12
`define AIO_ST_POINT_LSB     16

// ****************************************************************
// pin synchroniser width
// ****************************************************************
`define AIO_PIN_W        17

`endif

// >>> design/axis_io_pkg.sv
package axis_io_pkg;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_HOME,
    OP_MOVE
  } op_state_t;

  typedef logic signed [31:0] pos_t;

endpackage : axis_io_pkg

// >>> design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,  // system clock
  input  wire logic         rst_n,    // async reset, active low
  input  wire logic [W-1:0] pin_in,   // raw pin levels
  output var  logic [W-1:0] pin_out   // synchronised levels
);

  logic [W-1:0] meta_q;

  // ****************************************************************
  // two-stage synchroniser
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q  <= '0;
      pin_out <= '0;
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

// >>> design/status_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "axis_io_cfg.svh"

module status_select (
  input  wire logic [`AIO_NUM_CODES-1:0] status_vec,  // one bit per code
  input  wire logic [`AIO_SEL_W-1:0]     sel,         // select code
  output var  logic                      sel_out      // chosen status
);

  // code 0 and undefined codes give a constant low
  always_comb begin
    sel_out = 1'b0;
    if (sel != '0 && sel < 4'(`AIO_NUM_CODES)) begin
      sel_out = status_vec[sel];
    end
  end

endmodule : status_select

`default_nettype wire

// >>> tb/axis_io_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module axis_io_asserts (
  input wire logic       clk_sys,              // clock
  input wire logic       rst_n,                // reset
  input wire logic       avs_read,             // read
  input wire logic       avs_write,            // write
  input wire logic       avs_waitrequest,      // stall
  input wire logic       alarm_active,         // alarm in
  input wire logic [7:0] alarm_number,         // alarm code
  input wire logic       alarm_n,              // alarm out
  input wire logic [7:0] point_number_outputs, // point out
  input wire logic       drive_on_status,      // servo out
  input wire logic       move_start,           // start pulse
  input wire logic       end_output,           // end
  input wire logic       busy_output,          // busy
  input wire logic       run_cmd_active,       // run cmd
  input wire logic       op_error              // error end
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus not answered");
  alarm_level_a: assert property ($past(rst_n) |->
    alarm_n == !$past(alarm_active)) else $error("alarm_n wrong");
  alarm_number_a: assert property ($past(rst_n) && $past(alarm_active)
    |-> point_number_outputs == $past(alarm_number)) else $error("no alarm no");
  servo_block_a: assert property ($past(alarm_active)
    |-> !drive_on_status) else $error("servo on in alarm");
  start_pulse_a: assert property (move_start |=> !move_start)
    else $error("start pulse too long");
  end_low_a: assert property (move_start |-> !end_output)
    else $error("end high at start");
  busy_after_a: assert property (move_start |=> busy_output)
    else $error("busy late");
  end_hold_a: assert property ($rose(end_output) |->
    !$past(run_cmd_active)) else $error("end under run cmd");
  error_end_a: assert property (op_error && !end_output |=>
    !end_output) else $error("end after error");
  cover property (move_start);
  cover property (op_error);
  cover property ($fell(alarm_n));
endmodule : axis_io_asserts
bind axis_parallel_io_handshake axis_io_asserts u_axis_io_asserts (.*);
`default_nettype wire

// >>> tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic clk_sys,  // clock
  input  wire logic rst_n,    // reset
  input  wire logic go,       // move or home pulse
  input  wire logic stop,     // stop pulse
  output var  logic op_done,  // normal end
  output var  logic op_error  // error end
);
  // ****
  // operation timer
  // ****
  logic [3:0] cnt_q;
  logic       stop_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      stop_q <= 1'b0;
      op_done <= 1'b0;
      op_error <= 1'b0;
    end else begin
      op_done <= 1'b0;
      op_error <= 1'b0;
      if (go) begin
        cnt_q <= 4'ha;
        stop_q <= 1'b0;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
        if (stop) stop_q <= 1'b1;
        if (cnt_q == 4'h1) begin
          op_done <= !stop_q;
          op_error <= stop_q;
        end
      end
    end
  end
endmodule : core_model
`default_nettype wire

// >>> tb/axis_parallel_io_handshake_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "axis_io_cfg.svh"
module axis_parallel_io_handshake_test;
  localparam logic [31:0] codes = 32'h65a9_8730;
  localparam logic [7:0]  exps  = 8'hb6;
  logic        clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0;
  logic        avs_write = 1'b0, avs_waitrequest, run_cmd_active = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic [3:0]  avs_byteenable = 4'hf, selectable_outputs;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q, cur_speed = 32'h5;
  logic [8:0]  pins = 9'h000;
  logic [7:0]  psel = 8'h00, alarm_number = 8'h00, point_number_outputs;
  logic [7:0]  move_point, teach_point, n_mv = 8'h0, n_hm = 8'h0;
  logic [7:0]  n_tc = 8'h0, n_ds = 8'h0, n_ac = 8'h0, n_rc = 8'h0;
  logic        push_active = 1'b1, alarm_active = 1'b0, warn_active = 1'b0;
  logic        alarm_clearable = 1'b1, estop_active = 1'b1, rcom_active = 1'b1;
  logic        op_done, op_error, busy_output, end_output, alarm_n;
  logic        drive_on_status, move_start, teach_store, home_start;
  logic        jog_pos_cmd, jog_neg_cmd, decel_stop, speed_level_select;
  logic        alarm_clear, remaining_clear;
  int          num_errors = 0, comparisons = 0;
  axis_parallel_io_handshake u_axis_parallel_io_handshake (.*,
    .point_select_lines(psel), .jog_positive_input(pins[0]),
    .jog_negative_input(pins[1]), .manual_input(pins[2]),
    .origin_search_input(pins[3]), .interlock_input(pins[4]),
    .start_input(pins[5]), .teach_input(pins[6]), .reset_input(pins[7]),
    .servo_input(pins[8]), .cur_pos(32'h2), .target_pos(32'h2),
    .zone_plus(32'h10), .zone_minus(32'h0), .near_width(32'h0));
  core_model u_core_model (.clk_sys, .rst_n, .go(move_start | home_start),
    .stop(decel_stop), .op_done, .op_error);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (move_start) n_mv <= n_mv + 8'h1;
    if (home_start) n_hm <= n_hm + 8'h1;
    if (teach_store) n_tc <= n_tc + 8'h1;
    if (decel_stop) n_ds <= n_ds + 8'h1;
    if (alarm_clear) n_ac <= n_ac + 8'h1;
    if (remaining_clear) n_rc <= n_rc + 8'h1;
  end
  // ****
  // tasks
  // ****
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk_sys);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    rd_q = avs_readdata;
    chk(t < 50, 1'b1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task hit(input int b);
    pins[b] <= 1'b1;
    wt(8);
    pins[b] <= 1'b0;
    wt(8);
  endtask : hit
  task sel(input logic [3:0] c, input logic e);
    bus(1'b1, `AIO_OFS_OUTSEL, {16'h0, {4{c}}});
    wt(3);
    chk(selectable_outputs, {4{e}});
  endtask : sel
  task test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    #300us;
    num_errors++;
    test_done;
  end
  // ****
  // tests
  // ****
  initial begin
    wt(20);
    rst_n <= 1'b1;
    pins[4] <= 1'b1;
    pins[8] <= 1'b1;
    wt(4);
    chk(drive_on_status, 1'b1);
    bus(1'b0, `AIO_OFS_OUTSEL, 32'h0);
    chk(rd_q, 32'h4321);
    bus(1'b0, 6'h3c, 32'h0);
    chk(rd_q, 32'h0);
    for (int i = 0; i < 8; i++) sel(codes[4*i +: 4], exps[i]);
    bus(1'b1, `AIO_OFS_THRESH, 32'h5);
    sel(4'h6, 1'b0);
    hit(5);
    chk(n_mv, 8'h0);
    hit(3);
    chk(n_hm, 8'h1);
    sel(4'h4, 1'b1);
    push_active <= 1'b0;
    sel(4'h3, 1'b0);
    bus(1'b1, `AIO_OFS_ZONE_HI, 32'h5);
    sel(4'h5, 1'b1);
    psel <= 8'h29;
    wt(8); // setup kept short
    run_cmd_active <= 1'b1;
    hit(5);
    chk({n_mv, move_point}, 16'h0129);
    chk({busy_output, end_output}, 2'b10);
    run_cmd_active <= 1'b0;
    wt(4);
    chk({busy_output, end_output}, 2'b01);
    chk(point_number_outputs, 8'h29);
    sel(4'h1, 1'b1);
    sel(4'h2, 1'b1);
    pins[5] <= 1'b1;
    wt(6);
    pins[4] <= 1'b0;
    wt(20);
    chk({n_ds, end_output, drive_on_status}, 10'h005);
    pins[5] <= 1'b0;
    pins[4] <= 1'b1;
    pins[2] <= 1'b1;
    sel(4'h8, 1'b1);
    hit(5);
    chk(n_mv, 8'h2);
    psel <= 8'h07;
    hit(6);
    chk({n_tc, teach_point}, 16'h0107);
    pins[1] <= 1'b1;
    wt(6);
    chk(jog_neg_cmd, 1'b1);
    pins[1] <= 1'b0;
    wt(6);
    chk(jog_neg_cmd, 1'b0);
    bus(1'b1, `AIO_OFS_CTRL, 32'h1);
    pins[0] <= 1'b1;
    wt(6);
    chk(speed_level_select, 1'b0);
    pins[2] <= 1'b0;
    wt(6);
    chk({speed_level_select, jog_pos_cmd}, 2'b10);
    pins[0] <= 1'b0;
    alarm_number <= 8'h0c;
    alarm_active <= 1'b1;
    wt(4);
    chk({alarm_n, drive_on_status, point_number_outputs}, 10'h00c);
    hit(7);
    chk({n_ac, n_rc}, 16'h0101);
    alarm_active <= 1'b0;
    wt(4);
    chk({alarm_n, point_number_outputs}, 9'h100);
    test_done;
  end
endmodule : axis_parallel_io_handshake_test
`default_nettype wire
